// *** core/dmpy_pkg.sv ***
// Constants and types for the dual multiply-accumulate datapath.
package dmpy_pkg;
    localparam int DW = 16;
    localparam int OW = 17;
    localparam int AW = 40;
    localparam int PW = 16;
    localparam int RW = 8;
    localparam logic [PW-1:0] PTR_RST = 16'h0000;
    localparam logic [AW-1:0] ACC_RST = 40'h00_0000_0000;
    localparam logic [OW-1:0] MIN_OPND = 17'h1_8000;
    localparam logic [31:0] MUL_SAT = 32'h7fff_ffff;
    localparam logic [AW-1:0] RND_HALF = 40'h00_0000_8000;
    localparam logic [15:0] RND_TIE = 16'h8000;
    localparam logic [AW-1:0] SAT_POS_WIDE = 40'h7f_ffff_ffff;
    localparam logic [AW-1:0] SAT_NEG_WIDE = 40'h80_0000_0000;
    localparam logic [AW-1:0] SAT_POS_NARROW = 40'h00_7fff_ffff;
    localparam logic [AW-1:0] SAT_NEG_NARROW = 40'hff_8000_0000;
    localparam logic [PW-1:0] STEP_ONE = 16'h0001;
    localparam logic [PW-1:0] STEP_TWO = 16'h0002;
    localparam logic [PW-1:0] PAIR_MASK = 16'h0001;
    // Pointer modify codes.
    localparam logic [1:0] STEP_HOLD = 2'h0;
    localparam logic [1:0] STEP_INC = 2'h1;
    localparam logic [1:0] STEP_DEC = 2'h2;
    // Status mode bits that steer the arithmetic.
    typedef struct packed {
        logic fractional_mode_bit;
        logic multiply_saturation_mode;
        logic wide_overflow_mode;
        logic rounding_mode_bit;
        logic d_unit_saturation_mode;
        logic sign_extension_mode;
    } dmpy_modes_t;
    // Per-instruction qualifiers from the decoder.
    typedef struct packed {
        logic single_data_form;
        logic uns_x;
        logic uns_y;
        logic uns_c;
        logic rnd;
        logic wide_q;
        logic mac_one_en;
        logic mac_two_en;
        logic [1:0] step_x;
        logic [1:0] step_y;
        logic [1:0] step_c;
    } dmpy_instr_t;
    typedef enum logic [1:0] {
        S_IDLE = 2'b01,
        S_RUN = 2'b10
    } dmpy_state_t;
endpackage : dmpy_pkg

// *** core/dmpy_mac.sv ***
// One multiply-accumulate unit: multiply, shift, round, overflow and saturate.
`timescale 1ns/1ns
module dmpy_mac (
    input wire logic [dmpy_pkg::OW-1:0] op_a_i,
    input wire logic [dmpy_pkg::OW-1:0] op_b_i,
    input wire logic [dmpy_pkg::AW-1:0] acc_i,
    input wire logic accumulate_i,
    input wire logic rnd_i,
    input wire logic wide_i,
    input wire dmpy_pkg::dmpy_modes_t modes_i,
    output logic [dmpy_pkg::AW-1:0] res_o,
    output logic ovf_o
);
    // Full signed product; 17x17 fits 34 bits.
    logic signed [33:0] prod_full;
    logic [31:0] prod_shift;
    logic [31:0] prod32;
    logic mul_ovf;
    logic [dmpy_pkg::AW-1:0] prod40;
    logic [dmpy_pkg::AW-1:0] addend;
    logic [dmpy_pkg::AW:0] pre41;
    logic [dmpy_pkg::AW:0] sum41;
    logic [dmpy_pkg::AW:0] r41;
    logic tie;
    logic ovf_wide;
    logic ovf_narrow;
    logic [dmpy_pkg::AW-1:0] sat_val;

    assign prod_full = $signed(op_a_i) * $signed(op_b_i);
    // Fractional mode doubles the product before anything else.
    assign prod_shift = modes_i.fractional_mode_bit ? {prod_full[30:0], 1'b0} : prod_full[31:0];
    // The only product saturated is min times min, in fractional mode with multiply saturation on.
    assign mul_ovf = modes_i.multiply_saturation_mode & modes_i.fractional_mode_bit
                     & (op_a_i == dmpy_pkg::MIN_OPND) & (op_b_i == dmpy_pkg::MIN_OPND);
    assign prod32 = mul_ovf ? dmpy_pkg::MUL_SAT : prod_shift;
    // Sign-extend to accumulator width.
    assign prod40 = {{8{prod32[31]}}, prod32};
    // The plain multiply sees a zero addend, so old contents never leak in.
    assign addend = accumulate_i ? acc_i : dmpy_pkg::ACC_RST;
    // One guard bit above the accumulator catches the 40-bit carry-out.
    assign pre41 = {addend[dmpy_pkg::AW-1], addend} + {prod40[dmpy_pkg::AW-1], prod40};
    assign sum41 = pre41 + {1'b0, (rnd_i ? dmpy_pkg::RND_HALF : dmpy_pkg::ACC_RST)};
    // Unbiased mode clears bit 16 on an exact half so ties go to even.
    assign tie = modes_i.rounding_mode_bit & (pre41[15:0] == dmpy_pkg::RND_TIE);
    assign r41 = rnd_i ? {sum41[dmpy_pkg::AW:17], sum41[16] & ~tie, 16'h0000} : sum41;
    // Width of the overflow check follows the effective wide mode.
    assign ovf_wide = r41[dmpy_pkg::AW] ^ r41[dmpy_pkg::AW-1];
    assign ovf_narrow = ~((&r41[dmpy_pkg::AW:31]) | ~(|r41[dmpy_pkg::AW:31]));
    assign ovf_o = wide_i ? ovf_wide : ovf_narrow;
    // Saturation limit takes the sign of the true result.
    assign sat_val = wide_i ? (r41[dmpy_pkg::AW] ? dmpy_pkg::SAT_NEG_WIDE : dmpy_pkg::SAT_POS_WIDE)
                            : (r41[dmpy_pkg::AW] ? dmpy_pkg::SAT_NEG_NARROW : dmpy_pkg::SAT_POS_NARROW);
    assign res_o = (ovf_o & modes_i.d_unit_saturation_mode) ? sat_val : r41[dmpy_pkg::AW-1:0];
endmodule : dmpy_mac

// *** core/dmpy_top.sv ***
// Dual MAC datapath: accumulate and plain multiply in parallel, with repeat.
`timescale 1ns/1ns
module dmpy_top (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic [dmpy_pkg::RW-1:0] repeat_count_i,
    input wire dmpy_pkg::dmpy_instr_t instr_i,
    input wire dmpy_pkg::dmpy_modes_t modes_i,
    input wire logic [dmpy_pkg::DW-1:0] data_read_bus_d_i,
    input wire logic [dmpy_pkg::DW-1:0] data_read_bus_y_i,
    input wire logic [dmpy_pkg::DW-1:0] coeff_read_bus_first_i,
    input wire logic [dmpy_pkg::DW-1:0] coeff_read_bus_second_i,
    input wire logic [dmpy_pkg::AW-1:0] accumulator_x_i,
    input wire logic [dmpy_pkg::AW-1:0] accumulator_y_i,
    input wire logic [dmpy_pkg::PW-1:0] ptr_x_i,
    input wire logic [dmpy_pkg::PW-1:0] ptr_y_i,
    input wire logic [dmpy_pkg::PW-1:0] coefficient_pointer_i,
    input wire logic flag_clear_x_i,
    input wire logic flag_clear_y_i,
    output logic [dmpy_pkg::AW-1:0] accumulator_x_o,
    output logic [dmpy_pkg::AW-1:0] accumulator_y_o,
    output logic acc_wr_x_o,
    output logic acc_wr_y_o,
    output logic acc_overflow_flag_dest_x_o,
    output logic acc_overflow_flag_dest_y_o,
    output logic [dmpy_pkg::PW-1:0] ptr_x_o,
    output logic [dmpy_pkg::PW-1:0] ptr_y_o,
    output logic [dmpy_pkg::PW-1:0] coefficient_pointer_o,
    output logic [dmpy_pkg::PW-1:0] coeff_addr_hi_o,
    output logic [dmpy_pkg::PW-1:0] coeff_addr_lo_o,
    output logic busy_o
);
    // Widen a 16-bit memory value to the 17-bit multiplier input.
    function automatic logic [dmpy_pkg::OW-1:0] ext17(input logic [dmpy_pkg::DW-1:0] v,
                                                      input logic uns, input logic sx);
        ext17 = (uns | ~sx) ? {1'b0, v} : {v[dmpy_pkg::DW-1], v};
    endfunction : ext17

    // Apply one post-modify step to an address pointer.
    function automatic logic [dmpy_pkg::PW-1:0] step_ptr(input logic [dmpy_pkg::PW-1:0] p,
                                                         input logic [1:0] code,
                                                         input logic [dmpy_pkg::PW-1:0] amt);
        step_ptr = (code == dmpy_pkg::STEP_INC) ? p + amt :
                   (code == dmpy_pkg::STEP_DEC) ? p - amt : p;
    endfunction : step_ptr

    // Control state.
    dmpy_pkg::dmpy_state_t state_q;
    dmpy_pkg::dmpy_state_t state_d;
    logic [dmpy_pkg::RW-1:0] rpt_q;
    logic [dmpy_pkg::RW-1:0] rpt_d;
    // Instruction and modes held steady for the length of a repeat.
    dmpy_pkg::dmpy_instr_t instr_q;
    dmpy_pkg::dmpy_modes_t modes_q;
    // Result, flag and pointer registers that drive the outputs.
    logic [dmpy_pkg::AW-1:0] acc_x_q;
    logic [dmpy_pkg::AW-1:0] acc_y_q;
    logic wr_x_q;
    logic wr_y_q;
    logic ovf_x_q;
    logic ovf_y_q;
    logic [dmpy_pkg::PW-1:0] ptr_x_q;
    logic [dmpy_pkg::PW-1:0] ptr_y_q;
    logic [dmpy_pkg::PW-1:0] ptr_c_q;
    logic [dmpy_pkg::PW-1:0] caddr_hi_q;
    logic [dmpy_pkg::PW-1:0] caddr_lo_q;
    logic busy_q;

    // Selection of the working instruction and sources.
    // Idle cycles without a start run no pass at all.
    wire idle = (state_q == dmpy_pkg::S_IDLE);
    wire exec = idle ? start_i : 1'b1;
    wire first = idle;
    dmpy_pkg::dmpy_instr_t ci;
    dmpy_pkg::dmpy_modes_t cm;
    assign ci = first ? instr_i : instr_q;
    assign cm = first ? modes_i : modes_q;
    // Later repeat passes feed back the unit's own results and pointers.
    wire [dmpy_pkg::AW-1:0] src_x = first ? accumulator_x_i : acc_x_q;
    wire [dmpy_pkg::AW-1:0] src_y = first ? accumulator_y_i : acc_y_q;
    wire [dmpy_pkg::PW-1:0] px = first ? ptr_x_i : ptr_x_q;
    wire [dmpy_pkg::PW-1:0] py = first ? ptr_y_i : ptr_y_q;
    wire [dmpy_pkg::PW-1:0] pc = first ? coefficient_pointer_i : ptr_c_q;
    wire form = ci.single_data_form;
    // Wide qualifier forces the mode locally; the stored bit is never written.
    wire wide_eff = cm.wide_overflow_mode | ci.wide_q;
    // Two-data form honours sign-extension mode; single-data form sign-extends.
    wire sx = form | cm.sign_extension_mode;

    // Operand routing: unit one always takes the X operand.
    wire [dmpy_pkg::OW-1:0] a_one = ext17(data_read_bus_d_i, ci.uns_x, sx);
    // Unit two takes Y in the two-data form, the shared X otherwise.
    wire [dmpy_pkg::OW-1:0] a_two = form ? a_one : ext17(data_read_bus_y_i, ci.uns_y, sx);
    // First coefficient bus carries the shared or low coefficient.
    wire [dmpy_pkg::OW-1:0] b_one = ext17(coeff_read_bus_first_i, ci.uns_c, sx);
    // High half on the second bus goes to the accumulating unit two.
    wire [dmpy_pkg::OW-1:0] b_two = form ? ext17(coeff_read_bus_second_i, ci.uns_c, sx) : b_one;

    wire [dmpy_pkg::AW-1:0] res_one;
    wire [dmpy_pkg::AW-1:0] res_two;
    wire ovf_one;
    wire ovf_two;

    // Unit one accumulates into X in the two-data form, else plain multiply.
    dmpy_mac u_mac_unit_one (
        .op_a_i(a_one),
        .op_b_i(b_one),
        .acc_i(src_x),
        .accumulate_i(~form),
        .rnd_i(ci.rnd),
        .wide_i(wide_eff),
        .modes_i(cm),
        .res_o(res_one),
        .ovf_o(ovf_one)
    );

    // Unit two multiplies into Y in the two-data form, else accumulates.
    dmpy_mac u_mac_unit_two (
        .op_a_i(a_two),
        .op_b_i(b_two),
        .acc_i(src_y),
        .accumulate_i(form),
        .rnd_i(ci.rnd),
        .wide_i(wide_eff),
        .modes_i(cm),
        .res_o(res_two),
        .ovf_o(ovf_two)
    );

    // A disabled flow drops its write but its pointer still moves.
    wire do_x = exec & ci.mac_one_en;
    wire do_y = exec & ci.mac_two_en;
    // High/low pairing makes a coefficient post-increment step two words.
    wire [dmpy_pkg::PW-1:0] c_amt = form ? dmpy_pkg::STEP_TWO : dmpy_pkg::STEP_ONE;
    // Paired low address: plus one when even, minus one when odd.
    wire [dmpy_pkg::PW-1:0] pc_pair = pc ^ dmpy_pkg::PAIR_MASK;

    // Repeat sequencing: count holds the passes still to run after the current one.
    always_comb
    begin
        state_d = state_q;
        rpt_d = rpt_q;
        case (state_q)
            dmpy_pkg::S_IDLE:
            begin
                // A nonzero count keeps the datapath running extra passes.
                if (start_i && (repeat_count_i != '0))
                begin
                    state_d = dmpy_pkg::S_RUN;
                    rpt_d = repeat_count_i - 8'h01;
                end
            end
            dmpy_pkg::S_RUN:
            begin
                // Starts during a repeat are ignored; the decoder sees busy.
                if (rpt_q == '0)
                begin
                    state_d = dmpy_pkg::S_IDLE;
                end
                else
                begin
                    rpt_d = rpt_q - 8'h01;
                end
            end
            default:
            begin
                state_d = dmpy_pkg::S_IDLE;
                rpt_d = '0;
            end
        endcase
    end

    // Sequencer and held instruction.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= dmpy_pkg::S_IDLE;
            rpt_q <= '0;
            instr_q <= '0;
            modes_q <= '0;
            busy_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            rpt_q <= rpt_d;
            instr_q <= ci;
            modes_q <= cm;
            busy_q <= (state_d == dmpy_pkg::S_RUN);
        end
    end

    // Results and write strobes land together, one cycle after the pass.
    // Outside a pass a unit reloads its source, so results follow the accumulator inputs until the next start.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            acc_x_q <= dmpy_pkg::ACC_RST;
            acc_y_q <= dmpy_pkg::ACC_RST;
            wr_x_q <= 1'b0;
            wr_y_q <= 1'b0;
        end
        else
        begin
            acc_x_q <= do_x ? res_one : src_x;
            acc_y_q <= do_y ? res_two : src_y;
            wr_x_q <= do_x;
            wr_y_q <= do_y;
        end
    end

    // Flags are sticky: overflow sets, and a set beats a same-cycle clear.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ovf_x_q <= 1'b0;
            ovf_y_q <= 1'b0;
        end
        else
        begin
            ovf_x_q <= (do_x & ovf_one) | (ovf_x_q & ~flag_clear_x_i);
            ovf_y_q <= (do_y & ovf_two) | (ovf_y_q & ~flag_clear_y_i);
        end
    end

    // Address generators update even when their unit is disabled.
    // A pointer only moves on a pass, so idle cycles leave the last addresses visible.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ptr_x_q <= dmpy_pkg::PTR_RST;
            ptr_y_q <= dmpy_pkg::PTR_RST;
            ptr_c_q <= dmpy_pkg::PTR_RST;
            caddr_hi_q <= dmpy_pkg::PTR_RST;
            caddr_lo_q <= dmpy_pkg::PTR_RST;
        end
        else if (exec)
        begin
            ptr_x_q <= step_ptr(px, ci.step_x, dmpy_pkg::STEP_ONE);
            ptr_y_q <= step_ptr(py, ci.step_y, dmpy_pkg::STEP_ONE);
            ptr_c_q <= step_ptr(pc, ci.step_c, c_amt);
            caddr_hi_q <= pc;
            caddr_lo_q <= form ? pc_pair : pc;
        end
    end

    assign accumulator_x_o = acc_x_q;
    assign accumulator_y_o = acc_y_q;
    assign acc_wr_x_o = wr_x_q;
    assign acc_wr_y_o = wr_y_q;
    assign acc_overflow_flag_dest_x_o = ovf_x_q;
    assign acc_overflow_flag_dest_y_o = ovf_y_q;
    assign ptr_x_o = ptr_x_q;
    assign ptr_y_o = ptr_y_q;
    assign coefficient_pointer_o = ptr_c_q;
    assign coeff_addr_hi_o = caddr_hi_q;
    assign coeff_addr_lo_o = caddr_lo_q;
    assign busy_o = busy_q;

    // Reference plain product for the simple mode set, used only by a check.
    wire signed [33:0] ref_y = $signed(a_two) * $signed(b_two);
    wire plain_y = do_y & ~form & ~ci.rnd & ~cm.fractional_mode_bit & ~ovf_two;

    // The checks run on the datapath clock and rest while reset is held.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_both_units_write: assert property (do_x & do_y |=> wr_x_q & wr_y_q)
        else $error("parallel results not both written");
    a_plain_no_acc: assert property (plain_y |=> acc_y_q == {{8{$past(ref_y[31])}}, $past(ref_y[31:0])})
        else $error("plain multiply result wrong");
    a_flag_set: assert property (do_x & ovf_one |=> ovf_x_q)
        else $error("overflow did not set flag");
    a_flag_sticky: assert property (ovf_y_q & ~flag_clear_y_i |=> ovf_y_q)
        else $error("overflow flag cleared by datapath");
    // The x flag must survive passes that do not overflow until a clear arrives.
    a_flag_hold_x: assert property (ovf_x_q & ~flag_clear_x_i |=> ovf_x_q)
        else $error("overflow flag x cleared by datapath");
    a_pair_addr: assert property (exec & form |=> coeff_addr_lo_o == (coeff_addr_hi_o ^ dmpy_pkg::PAIR_MASK))
        else $error("low coefficient address not paired");
    a_cdp_step_two: assert property (exec & form & (ci.step_c == dmpy_pkg::STEP_INC)
                                     |=> ptr_c_q == $past(pc) + dmpy_pkg::STEP_TWO)
        else $error("coefficient pointer did not step two");
    a_disabled_ptr: assert property (exec & ~ci.mac_one_en & (ci.step_x == dmpy_pkg::STEP_INC)
                                     |=> ~wr_x_q && ptr_x_q == $past(px) + dmpy_pkg::STEP_ONE)
        else $error("disabled flow mishandled pointer or write");
    a_repeat_busy: assert property (idle & start_i & (repeat_count_i == 8'h02)
                                    |=> busy_q [*2] ##1 ~busy_q)
        else $error("repeat length wrong");
    a_sat_limit: assert property (do_x & ovf_one & cm.d_unit_saturation_mode & ~wide_eff
                                  |=> acc_x_q == dmpy_pkg::SAT_POS_NARROW || acc_x_q == dmpy_pkg::SAT_NEG_NARROW)
        else $error("saturation limit wrong");

    // Cover points for repeat, the single-data form, saturation and the set-clear race.
    c_repeat_run: cover property (idle & start_i & (repeat_count_i != '0));
    c_single_form: cover property (do_x & do_y & form);
    c_overflow_sat: cover property (do_y & ovf_two & cm.d_unit_saturation_mode);
    c_flag_race: cover property (do_x & ovf_one & flag_clear_x_i);
endmodule : dmpy_top

// *** testbench/dmpy_coeff_mem.sv ***
// Coefficient memory model that answers both coefficient read buses from one effective address.
`timescale 1ns/1ns
module dmpy_coeff_mem (
    input wire logic [dmpy_pkg::PW-1:0] ea_i,
    output logic [dmpy_pkg::DW-1:0] hi_data_o,
    output logic [dmpy_pkg::DW-1:0] lo_data_o
);
    // Small on-chip array; the bench never places a coefficient outside it.
    logic [dmpy_pkg::DW-1:0] mem_q [16];
    // The low half sits at the paired address, which flips the lowest address bit.
    logic [dmpy_pkg::PW-1:0] pair_addr;
    assign pair_addr = ea_i ^ dmpy_pkg::PAIR_MASK;
    // High half at the address itself; unwritten words stay unknown, which is no kinder than memory.
    assign hi_data_o = mem_q[ea_i[3:0]];
    assign lo_data_o = mem_q[pair_addr[3:0]];
endmodule : dmpy_coeff_mem

// *** testbench/dmpy_top_tb.sv ***
// Self-checking bench for the dual multiply-accumulate datapath.
`timescale 1ns/1ns
module dmpy_top_tb;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic start_i = 1'b0;
    logic [7:0] rep = 8'h00;
    dmpy_pkg::dmpy_instr_t ins = '0;
    dmpy_pkg::dmpy_modes_t md = '0;
    logic [15:0] d = 16'h0000, y = 16'h0000, px = 16'h1000, py = 16'h1100, pc = 16'h2000;
    logic [39:0] ax = 40'h0, ay = 40'h0, rx, ry;
    logic clr_x = 1'b0, clr_y = 1'b0, wx, wy, fx, fy, busy;
    logic [15:0] qx, qy, qc, ahi, alo, hi, lo;
    int errors = 0;
    int checked = 0;
    // Clock at 100 MHz.
    always #5 clk_i = ~clk_i;
    dmpy_coeff_mem i_dmpy_coeff_mem (.ea_i(pc), .hi_data_o(hi), .lo_data_o(lo));
    // The first bus carries the low half in single-data form and the shared coefficient otherwise.
    dmpy_top i_dmpy_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start_i), .repeat_count_i(rep),
        .instr_i(ins), .modes_i(md), .data_read_bus_d_i(d), .data_read_bus_y_i(y),
        .coeff_read_bus_first_i(ins.single_data_form ? lo : hi), .coeff_read_bus_second_i(hi),
        .accumulator_x_i(ax), .accumulator_y_i(ay), .ptr_x_i(px), .ptr_y_i(py), .coefficient_pointer_i(pc),
        .flag_clear_x_i(clr_x), .flag_clear_y_i(clr_y), .accumulator_x_o(rx), .accumulator_y_o(ry),
        .acc_wr_x_o(wx), .acc_wr_y_o(wy), .acc_overflow_flag_dest_x_o(fx), .acc_overflow_flag_dest_y_o(fy),
        .ptr_x_o(qx), .ptr_y_o(qy), .coefficient_pointer_o(qc), .coeff_addr_hi_o(ahi), .coeff_addr_lo_o(alo),
        .busy_o(busy));
    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    // Compares one value; four-state equality so an unknown matches only the same unknown.
    task automatic chk(input string w, input logic [39:0] s, input logic [39:0] e);
        checked++;
        if (s !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", w, e, s);
        end
    endtask : chk
    // Operand widening in the two-data form.
    function automatic logic [16:0] ext(input logic [15:0] v, input logic u);
        return (u | ~md.sign_extension_mode) ? {1'b0, v} : {v[15], v};
    endfunction : ext
    // Reference for one unit: product, shift, product saturation, add, round, overflow, saturation.
    function automatic logic [40:0] xm(input logic [16:0] a, input logic [16:0] b, input logic [39:0] acc,
        input logic accum, input logic rnd, input logic wide);
        logic signed [33:0] p;
        logic [31:0] p32;
        logic [40:0] s;
        logic tie;
        logic ov;
        p = $signed(a) * $signed(b);
        if (md.fractional_mode_bit)
            p = p <<< 1;
        p32 = p[31:0];
        if (md.multiply_saturation_mode && md.fractional_mode_bit && a == dmpy_pkg::MIN_OPND && b == a)
            p32 = dmpy_pkg::MUL_SAT;
        s = {{9{p32[31]}}, p32} + (accum ? {acc[39], acc} : 41'h0);
        tie = s[15:0] == dmpy_pkg::RND_TIE;
        if (rnd)
            s = (s + 41'h8000) & ~41'hffff;
        if (rnd && md.rounding_mode_bit && tie)
            s[16] = 1'b0;
        ov = wide ? s[40] != s[39] : !(&s[40:31] || s[40:31] == 10'h0);
        if (ov && md.d_unit_saturation_mode)
            s[39:0] = s[40] ? (wide ? dmpy_pkg::SAT_NEG_WIDE : dmpy_pkg::SAT_NEG_NARROW)
                : (wide ? dmpy_pkg::SAT_POS_WIDE : dmpy_pkg::SAT_POS_NARROW);
        return {ov, s[39:0]};
    endfunction : xm
    // Places a coefficient pair in the model memory.
    task automatic setc(input logic [15:0] hv, input logic [15:0] lv);
        i_dmpy_coeff_mem.mem_q[pc[3:0]] = hv;
        i_dmpy_coeff_mem.mem_q[pc[3:0] ^ 4'h1] = lv;
    endtask : setc
    // Issues one pass and waits, bounded, for the write pulse; a hang ends the run.
    task automatic run(input logic [7:0] f, input logic [5:0] s);
        int k;
        @(negedge clk_i);
        ins = {f, s};
        start_i = 1'b1;
        for (k = 0; k < 8 && !(wx | wy); k++)
        begin
            @(negedge clk_i);
            start_i = 1'b0;
        end
        if (k == 8)
        begin
            errors++;
            report_and_stop();
        end
    endtask : run
    // Results and both write pulses after a pass.
    task automatic post(input logic [40:0] ex, input logic [40:0] ey);
        chk("result x", rx, ex[39:0]);
        chk("result y", ry, ey[39:0]);
        chk("write pair", {wx, wy}, 2'h3);
    endtask : post
    // Two-data form over signed, unsigned-by-mode and qualified-unsigned operands.
    task automatic t_two();
        logic [15:0] dv [3] = '{16'hfffe, 16'h8000, 16'hffff};
        logic [15:0] yv [3] = '{16'h0003, 16'hffff, 16'h8000};
        logic [15:0] cv [3] = '{16'h4000, 16'h0002, 16'h8000};
        logic [7:0] fv [3] = '{8'h03, 8'h03, 8'h73};
        logic [5:0] mv [3] = '{6'h21, 6'h00, 6'h01};
        for (int i = 0; i < 3; i++)
        begin
            d = dv[i];
            y = yv[i];
            md = mv[i];
            ax = 40'h00_0000_0100;
            setc(cv[i], 16'h0000);
            run(fv[i], 6'h19);
            post(xm(ext(d, ins.uns_x), ext(hi, ins.uns_c), ax, 1, 0, 0),
                xm(ext(y, ins.uns_y), ext(hi, ins.uns_c), ax, 0, 0, 0));
            chk("pointers", {qx, qy}, {px + 16'h1, py - 16'h1});
            chk("coef pointer", qc, pc + 16'h1);
            chk("coef addrs", {ahi, alo}, {pc, pc});
        end
        $display("two-data test done");
    endtask : t_two
    // Single-data form at an odd then an even coefficient address.
    task automatic t_single();
        md = '0;
        d = 16'hfe00;
        px = 16'h10ff;
        ax = 40'hff_8000_0000;
        ay = 40'h00_0000_8000;
        pc = 16'h2000;
        setc(16'h8000, 16'h4000);
        for (int i = 1; i >= 0; i--)
        begin
            pc = i ? 16'h2001 : 16'h2000;
            run(8'hd3, 6'h21);
            post(xm({1'b0, d}, {1'b0, lo}, ax, 0, 0, 0), xm({1'b0, d}, {1'b0, hi}, ay, 1, 0, 0));
            chk("pointers", {qx, qc}, {px - 16'h1, pc + 16'h2});
            chk("coef addrs", {ahi, alo}, {pc, pc ^ 16'h1});
        end
        chk("known x", rx, 40'h00_3f80_0000);
        chk("known y", ry, 40'h00_7f00_8000);
        $display("single-data test done");
    endtask : t_single
    // Accumulator overflow, wide qualifier, sticky flag, clear, then product saturation.
    task automatic t_ovf();
        logic [40:0] e;
        md = 6'h03;
        d = 16'h7fff;
        y = 16'h0000;
        ax = 40'h00_7fff_ff00;
        setc(16'h7fff, 16'h0000);
        for (int w = 0; w < 3; w++)
        begin
            md = (w == 2) ? 6'h0b : 6'h03;
            run((w == 1) ? 8'h07 : 8'h03, 6'h00);
            e = xm(17'h07fff, 17'h07fff, ax, 1, 0, w != 0);
            chk("result x", rx, e[39:0]);
            chk("flags", {fx, fy}, 2'h2);
        end
        @(negedge clk_i);
        clr_x = 1'b1;
        @(negedge clk_i);
        clr_x = 1'b0;
        chk("flag x cleared", fx, 1'b0);
        d = 16'h8000;
        y = 16'h8000;
        ax = 40'h0;
        setc(16'h8000, 16'h0000);
        for (int m = 0; m < 2; m++)
        begin
            md = m ? 6'h31 : 6'h21;
            run(8'h03, 6'h00);
            post(xm(17'h18000, 17'h18000, ax, 1, 0, 0), xm(17'h18000, 17'h18000, ax, 0, 0, 0));
        end
        $display("overflow test done");
    endtask : t_ovf
    // Rounding on an exact tie with both rounding modes.
    task automatic t_round();
        d = 16'h0001;
        y = 16'h0005;
        setc(16'h8000, 16'h0000);
        for (int r = 0; r < 2; r++)
        begin
            md = r ? 6'h04 : 6'h00;
            run(8'h3b, 6'h00);
            post(xm(17'h00001, 17'h08000, ax, 1, 1, 0), xm(17'h00005, 17'h08000, ax, 0, 1, 0));
            chk("tie y", ry, r ? 40'h2_0000 : 40'h3_0000);
        end
        $display("rounding test done");
    endtask : t_round
    // Three passes under repeat while a second start is offered during busy.
    task automatic t_repeat();
        int n = 0;
        md = 6'h01;
        d = 16'h0002;
        y = 16'h0003;
        setc(16'h0010, 16'h0000);
        @(negedge clk_i);
        ins = {8'h03, 6'h15};
        rep = 8'h02;
        start_i = 1'b1;
        for (int k = 0; k < 8; k++)
        begin
            @(negedge clk_i);
            start_i = (k < 2);
            n += wx;
            if (k == 0)
                chk("busy", busy, 1'b1);
            if (k == 2)
            begin
                chk("result x", rx, 40'h60);
                chk("result y", ry, 40'h30);
            end
        end
        rep = 8'h00;
        chk("write count", n, 3);
        chk("pointers", {qx, qc}, {px + 16'h3, pc + 16'h3});
        chk("busy end", busy, 1'b0);
        $display("repeat test done");
    endtask : t_repeat
    // First unit disabled: no write, result held, pointers still step.
    task automatic t_off();
        md = 6'h01;
        d = 16'h0003;
        y = 16'h0004;
        ax = 40'h12_3456_789a;
        setc(16'h0002, 16'h0000);
        run(8'h01, 6'h15);
        chk("writes", {wx, wy}, 2'h1);
        chk("held x", rx, ax);
        chk("result y", ry, 40'h8);
        chk("pointers", {qx, qy}, {px + 16'h1, py + 16'h1});
        chk("coef pointer", qc, pc + 16'h1);
        $display("disable test done");
    endtask : t_off
    // Reset for four cycles, then every scenario in turn.
    initial
    begin
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        rst_n_i = 1'b1;
        t_two();
        t_single();
        t_ovf();
        t_round();
        t_repeat();
        t_off();
        report_and_stop();
    end
endmodule : dmpy_top_tb
